// ---- verilog/mfi_defs.vh ----
// Constants shared by the multi-function interrupt source logic
`ifndef MFI_DEFS_VH
`define MFI_DEFS_VH

// Number of multi-function groups
`define MFI_NUM_GROUPS 4
// Width of one group index inside the group map
`define MFI_GRP_W 2

// Fixed source slots
`define MFI_SRC_PIN 0
`define MFI_SRC_SERIAL 1
`define MFI_SRC_NV 2
`define MFI_SRC_LV 3
`define MFI_SRC_TMR_BASE 4
`define MFI_NUM_FIXED 4

// Each timer owns three slots: period, A and B match
`define MFI_TMR_SLOTS 3
`define MFI_TMR_P 0
`define MFI_TMR_A 1
`define MFI_TMR_B 2

// Reset values
`define MFI_GIE_RESET 1'b0
`define MFI_FLAG_RESET 1'b0
`define MFI_PIN_IDLE 1'b1

`endif

// ---- verilog/mfi_ctrl.v ----
// Multi-function interrupt request flags, gating, service and wake-up
`timescale 1ns/100ps
`default_nettype none
`include "mfi_defs.vh"


module mfi_ctrl #(
  parameter NUM_TIMERS = 2,
  // One bit per timer, set for an enhanced timer with a B comparator
  parameter [NUM_TIMERS-1:0] ENHANCED_MASK = 2'b10,
  // Group index for each source slot, two bits per slot, slot 0 lowest
  parameter [`MFI_GRP_W*(`MFI_NUM_FIXED+3*NUM_TIMERS)-1:0] GROUP_MAP =
    20'hFEA50
) (
  // Clock, reset and freeze
  input wire clk,
  input wire reset_n,
  input wire clk_en,

  // Pins and peripheral events
  input wire peripheral_irq_pin,
  input wire serial_byte_done,
  input wire nv_write_done,
  input wire supply_monitor_low,
  input wire [NUM_TIMERS-1:0] timer_period_match,
  input wire [NUM_TIMERS-1:0] timer_a_match,
  input wire [NUM_TIMERS-1:0] timer_b_match,

  // Source and group enables
  input wire pin_interrupt_enable,
  input wire serial_interrupt_enable,
  input wire nv_write_interrupt_enable,
  input wire low_voltage_interrupt_enable,
  input wire [NUM_TIMERS-1:0] timer_period_match_enable,
  input wire [NUM_TIMERS-1:0] timer_a_match_enable,
  input wire [NUM_TIMERS-1:0] timer_b_match_enable,
  input wire [`MFI_NUM_GROUPS-1:0] group_interrupt_enable,

  // Software writes to flags and the global enable
  input wire [`MFI_NUM_FIXED+3*NUM_TIMERS-1:0] flag_wr_en,
  input wire [`MFI_NUM_FIXED+3*NUM_TIMERS-1:0] flag_wr_data,
  input wire [`MFI_NUM_GROUPS-1:0] group_flag_wr_en,
  input wire [`MFI_NUM_GROUPS-1:0] group_flag_wr_data,
  input wire gie_wr_en,
  input wire gie_wr_data,

  // Processor side
  input wire stack_full,
  input wire ret_exec,
  input wire return_from_interrupt_exec,

  // Flags and service outputs
  output reg [`MFI_NUM_FIXED+3*NUM_TIMERS-1:0] source_flags,
  output reg [`MFI_NUM_GROUPS-1:0] group_request_flags,
  output reg global_interrupt_enable,
  output reg vector_call,
  output reg [`MFI_GRP_W-1:0] vector_group,
  output reg push_pc,
  output reg pop_pc,
  output reg wake_up
);

  localparam NSRC = `MFI_NUM_FIXED + 3 * NUM_TIMERS;
  localparam NGRP = `MFI_NUM_GROUPS;

  // Group index of a source slot
  function [`MFI_GRP_W-1:0] group_of;
    input integer slot;
    begin
      group_of = GROUP_MAP[slot*`MFI_GRP_W +: `MFI_GRP_W];
    end
  endfunction

  // Slot index of one comparator of one timer
  function integer timer_slot;
    input integer tmr;
    input integer which;
    begin
      timer_slot = `MFI_SRC_TMR_BASE + `MFI_TMR_SLOTS * tmr + which;
    end
  endfunction

  // Two-stage synchronisers for the asynchronous pin and the supply monitor
  // Pin resets to its idle level so that release gives no false edge
  // Monitor resets low, so a supply already low at release still flags
  reg pin_meta;
  reg pin_sync;
  reg pin_last;
  reg lv_meta;
  reg lv_sync;
  reg lv_last;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= `MFI_PIN_IDLE;
      pin_sync <= `MFI_PIN_IDLE;
      pin_last <= `MFI_PIN_IDLE;
      lv_meta <= 1'b0;
      lv_sync <= 1'b0;
      lv_last <= 1'b0;
    end else if (clk_en) begin
      pin_meta <= peripheral_irq_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
      lv_meta <= supply_monitor_low;
      lv_sync <= lv_meta;
      lv_last <= lv_sync;
    end
  end

  // Source events, one bit per slot
  reg [NSRC-1:0] set_event;
  integer t;

  always @* begin
    set_event = {NSRC{1'b0}};

    set_event[`MFI_SRC_PIN] = pin_last & ~pin_sync;

    set_event[`MFI_SRC_SERIAL] = serial_byte_done;

    set_event[`MFI_SRC_NV] = nv_write_done;

    // low supply onset
    // An edge, not a level, so software can clear it while still low
    set_event[`MFI_SRC_LV] = lv_sync & ~lv_last;

    for (t = 0; t < NUM_TIMERS; t = t + 1) begin
      set_event[timer_slot(t, `MFI_TMR_P)] = timer_period_match[t];
      set_event[timer_slot(t, `MFI_TMR_A)] = timer_a_match[t];
      // B slot only on enhanced timers
      set_event[timer_slot(t, `MFI_TMR_B)] =
        timer_b_match[t] & ENHANCED_MASK[t];
    end
  end

  // Source enables, one bit per slot
  reg [NSRC-1:0] source_enable;
  integer e;

  always @* begin
    source_enable = {NSRC{1'b0}};
    source_enable[`MFI_SRC_PIN] = pin_interrupt_enable;
    source_enable[`MFI_SRC_SERIAL] = serial_interrupt_enable;
    source_enable[`MFI_SRC_NV] = nv_write_interrupt_enable;
    source_enable[`MFI_SRC_LV] = low_voltage_interrupt_enable;
    for (e = 0; e < NUM_TIMERS; e = e + 1) begin
      source_enable[timer_slot(e, `MFI_TMR_P)] =
        timer_period_match_enable[e];
      source_enable[timer_slot(e, `MFI_TMR_A)] =
        timer_a_match_enable[e];
      // B enable only on enhanced timers
      source_enable[timer_slot(e, `MFI_TMR_B)] =
        timer_b_match_enable[e] & ENHANCED_MASK[e];
    end
  end

  // Slots that really exist; B slots of plain timers stay zero
  reg [NSRC-1:0] slot_exists;
  integer k;

  always @* begin
    slot_exists = {NSRC{1'b1}};
    for (k = 0; k < NUM_TIMERS; k = k + 1) begin
      slot_exists[timer_slot(k, `MFI_TMR_B)] = ENHANCED_MASK[k];
    end
  end

  // Next source flags
  reg [NSRC-1:0] next_source_flags;
  integer s;

  always @* begin
    next_source_flags = source_flags;
    for (s = 0; s < NSRC; s = s + 1) begin
      if (flag_wr_en[s]) begin
        next_source_flags[s] = flag_wr_data[s];
      end
      if (set_event[s]) begin
        next_source_flags[s] = 1'b1;
      end
    end
    // flags held; service never clears a source flag
    next_source_flags = next_source_flags & slot_exists;
  end

  // Group events and the pending condition of each group
  reg [NGRP-1:0] group_set;
  reg [NGRP-1:0] group_has_enabled;
  integer m;

  always @* begin
    group_set = {NGRP{1'b0}};
    group_has_enabled = {NGRP{1'b0}};
    for (m = 0; m < NSRC; m = m + 1) begin
      // member flag rise sets group flag
      if (next_source_flags[m] & ~source_flags[m]) begin
        group_set[group_of(m)] = 1'b1;
      end
      if (source_flags[m] & source_enable[m]) begin
        group_has_enabled[group_of(m)] = 1'b1;
      end
    end
  end

  wire [NGRP-1:0] group_pending = group_request_flags &
    group_interrupt_enable & group_has_enabled;
  wire take_irq = global_interrupt_enable & ~stack_full & (|group_pending);

  // Lowest pending group is taken first
  // Fixed order: a group that keeps refiring can starve the higher ones
  reg [`MFI_GRP_W-1:0] sel_group;
  integer g;

  always @* begin
    sel_group = {`MFI_GRP_W{1'b0}};
    for (g = NGRP - 1; g >= 0; g = g - 1) begin
      if (group_pending[g]) begin
        sel_group = g[`MFI_GRP_W-1:0];
      end
    end
  end

  // Next group flags
  reg [NGRP-1:0] next_group_flags;
  integer n;

  always @* begin
    next_group_flags = group_request_flags;
    for (n = 0; n < NGRP; n = n + 1) begin
      if (group_flag_wr_en[n]) begin
        next_group_flags[n] = group_flag_wr_data[n];
      end
      if (take_irq && (sel_group == n[`MFI_GRP_W-1:0])) begin
        next_group_flags[n] = 1'b0;
      end
      if (group_set[n]) begin
        next_group_flags[n] = 1'b1;
      end
    end
  end

  // Global enable; service entry outranks the returns and software
  reg next_gie;

  always @* begin
    next_gie = global_interrupt_enable;
    if (gie_wr_en) begin
      next_gie = gie_wr_data;
    end
    if (return_from_interrupt_exec) begin
      next_gie = 1'b1;
    end
    // only enable and group flag cleared
    if (take_irq) begin
      next_gie = 1'b0;
    end
  end

  // Wake-up looks at every flag, so enables play no part
  // Registered, so the pulse stands in the cycle the new flag first shows
  wire any_rise = (|(next_source_flags & ~source_flags)) |
    (|(next_group_flags & ~group_request_flags));

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      source_flags <= {NSRC{`MFI_FLAG_RESET}};
      group_request_flags <= {NGRP{`MFI_FLAG_RESET}};
      global_interrupt_enable <= `MFI_GIE_RESET;
      vector_call <= 1'b0;
      vector_group <= {`MFI_GRP_W{1'b0}};
      push_pc <= 1'b0;
      pop_pc <= 1'b0;
      wake_up <= 1'b0;
    end else if (clk_en) begin
      source_flags <= next_source_flags;
      group_request_flags <= next_group_flags;
      global_interrupt_enable <= next_gie;
      vector_call <= take_irq;
      if (take_irq) begin
        vector_group <= sel_group;
      end
      // only the program counter is pushed
      push_pc <= take_irq;
      // both returns restore the program counter
      pop_pc <= ret_exec | return_from_interrupt_exec;
      wake_up <= any_rise;
    end
  end

endmodule
`default_nettype wire

// ---- verification/mfi_monitor.sv ----
// Assertion checker for the multi-function interrupt logic
`timescale 1ns/100ps
`default_nettype none
module mfi_monitor #(
  parameter NUM_TIMERS = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic serial_byte_done,
  input wire logic [NUM_TIMERS-1:0] timer_period_match,
  input wire logic [3+3*NUM_TIMERS:0] flag_wr_en,
  input wire logic gie_wr_en,
  input wire logic stack_full,
  input wire logic ret_exec,
  input wire logic return_from_interrupt_exec,
  input wire logic [3+3*NUM_TIMERS:0] source_flags,
  input wire logic global_interrupt_enable,
  input wire logic vector_call,
  input wire logic push_pc,
  input wire logic pop_pc,
  input wire logic wake_up
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_call_push: assert property (vector_call |-> push_pc)
    else $error("call without pc push");
  chk_call_gate: assert property (vector_call |->
    $past(global_interrupt_enable) && !$past(stack_full))
    else $error("call while disabled or stack full");
  chk_call_gie: assert property (vector_call |-> !global_interrupt_enable)
    else $error("global enable kept on call");
  chk_serial_set: assert property (
    clk_en && serial_byte_done |=> source_flags[1])
    else $error("serial flag not set");
  chk_timer_set: assert property (
    clk_en && timer_period_match[0] |=> source_flags[4])
    else $error("timer flag not set");
  chk_flag_hold: assert property (
    ($past(source_flags) & ~$past(flag_wr_en) & ~source_flags) == '0)
    else $error("flag dropped without software write");
  chk_return_from_interrupt_gie: assert property (clk_en && return_from_interrupt_exec |=>
    pop_pc && (global_interrupt_enable || vector_call))
    else $error("return did not enable");
  chk_ret_keep: assert property (clk_en && ret_exec && !return_from_interrupt_exec &&
    !gie_wr_en && !global_interrupt_enable |=> pop_pc ##0 !global_interrupt_enable)
    else $error("plain return changed enable");
  chk_wake_rise: assert property (
    clk_en && |(source_flags & ~$past(source_flags)) |-> wake_up)
    else $error("no wake on flag rise");
  cover property (vector_call);
  cover property (wake_up);
  cover property (pop_pc && global_interrupt_enable);
endmodule
bind mfi_ctrl mfi_monitor #(.NUM_TIMERS(NUM_TIMERS)) mon_u (.*);
`default_nettype wire

// ---- verification/mfi_cpu_model.sv ----
// Program sequencer and stack model facing the interrupt logic
`timescale 1ns/100ps
`default_nettype none
module mfi_cpu_model #(
  parameter DEPTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic push_pc,
  input wire logic pop_pc,
  input wire logic do_ret,
  input wire logic do_return_from_interrupt,
  output logic stack_full,
  output logic ret_exec,
  output logic return_from_interrupt_exec
);
  int depth;
  initial {ret_exec, return_from_interrupt_exec} = 2'h0;
  always @(posedge clk or negedge reset_n)
    if (!reset_n) depth <= 0;
    else depth <= depth + int'(push_pc) - int'(pop_pc);
  assign stack_full = depth >= DEPTH;
  // returns only with a level stacked
  always @(posedge clk) begin
    ret_exec <= do_ret && depth > 0;
    return_from_interrupt_exec <= do_return_from_interrupt && depth > 0;
  end
endmodule
`default_nettype wire

// ---- verification/tb_mfi_ctrl.sv ----
// Self-checking testbench for the interrupt source logic
`timescale 1ns/100ps
`default_nettype none
module tb_mfi_ctrl;
  logic clk = 0, reset_n = 0, clk_en = 1, peripheral_irq_pin = 1;
  logic serial_byte_done = 0, nv_write_done = 0, supply_monitor_low = 0;
  logic [1:0] timer_period_match = '0, timer_a_match = '0;
  logic [1:0] timer_b_match = '0, timer_period_match_enable = '1;
  logic [1:0] timer_a_match_enable = '1, timer_b_match_enable = '1;
  logic pin_interrupt_enable = 1, serial_interrupt_enable = 1;
  logic nv_write_interrupt_enable = 1, low_voltage_interrupt_enable = 1;
  logic [3:0] group_interrupt_enable = '1, group_request_flags;
  logic [3:0] group_flag_wr_en = '0, group_flag_wr_data = '0;
  logic [9:0] flag_wr_en = '0, flag_wr_data = '0, source_flags;
  logic gie_wr_en = 0, gie_wr_data = 0, stack_full, ret_exec, return_from_interrupt_exec;
  logic global_interrupt_enable, vector_call, push_pc, pop_pc, wake_up;
  logic [1:0] vector_group;
  logic do_ret = 0, do_return_from_interrupt = 0;
  int n_errors = 0, checks = 0;
  mfi_ctrl dut_u (.*);
  mfi_cpu_model #(.DEPTH(1)) cpu_u (.*);
  initial forever #20 clk = ~clk;
  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for a taken interrupt
  task automatic wait_call;
    for (int i = 0; i < 12 && vector_call !== 1'b1; i++) tick;
    if (vector_call !== 1'b1) begin
      n_errors++;
      $display("BAD %0t no interrupt call", $time);
      conclude;
    end
  endtask
  task automatic pulse_return_from_interrupt;
    do_return_from_interrupt = 1; tick; do_return_from_interrupt = 0;
  endtask
  // Tick first so a pending return never meets the enable write
  task automatic clear_all;
    tick; flag_wr_en = '1; flag_wr_data = '0; gie_wr_en = 1; gie_wr_data = 0;
    group_flag_wr_en = '1; group_flag_wr_data = '0;
    tick; flag_wr_en = '0; gie_wr_en = 0; group_flag_wr_en = '0;
  endtask
  task automatic t_serial;
    serial_byte_done = 1; tick; serial_byte_done = 0;
    cmp(source_flags, 10'h002);
    cmp(group_request_flags, 4'h1);
    cmp(wake_up, 1'h1);
    tick; cmp(wake_up, 1'h0);
  endtask
  task automatic t_service;
    gie_wr_en = 1; gie_wr_data = 1; tick; gie_wr_en = 0;
    wait_call;
    cmp(vector_group, 2'h0);
    cmp({source_flags, group_request_flags}, 14'h0020);
    cmp(global_interrupt_enable, 1'h0);
    group_flag_wr_en = 4'h1; group_flag_wr_data = 4'h1; gie_wr_en = 1;
    tick; group_flag_wr_en = '0; gie_wr_en = 0; tick(6);
    cmp(global_interrupt_enable, 1'h1);
    pulse_return_from_interrupt; wait_call;
    cmp(push_pc, 1'h1);
    clear_all; pulse_return_from_interrupt; tick;
    cmp(global_interrupt_enable, 1'h1);
  endtask
  task automatic t_race;
    nv_write_interrupt_enable = 0; nv_write_done = 1; flag_wr_en = 10'h004;
    tick; nv_write_done = 0; flag_wr_en = '0;
    cmp(source_flags[2], 1'h1);
    tick(4);
    cmp({global_interrupt_enable, source_flags[2]}, 2'h3);
    nv_write_interrupt_enable = 1; wait_call;
    cmp(vector_group, 2'h1);
    tick; pulse_return_from_interrupt; clear_all;
  endtask
  task automatic t_timers;
    for (int k = 0; k < 6; k++) begin
      timer_period_match[k/3] = (k % 3 == 0);
      timer_a_match[k/3] = (k % 3 == 1);
      timer_b_match[k/3] = (k % 3 == 2);
      tick; {timer_period_match, timer_a_match, timer_b_match} = '0;
      cmp(source_flags, k == 2 ? 10'h000 : 10'h010 << k);
      clear_all;
    end
  endtask
  task automatic t_pin_lv;
    // pin taken as routed to the interrupt input
    peripheral_irq_pin = 0; supply_monitor_low = 1; tick(4);
    cmp(source_flags, 10'h009);
    peripheral_irq_pin = 1; gie_wr_en = 1; gie_wr_data = 1; tick;
    gie_wr_en = 0; wait_call;
    cmp({vector_group, source_flags}, 12'h009);
    tick; do_ret = 1; tick; do_ret = 0; tick;
    cmp(pop_pc, 1'h1);
    cmp(global_interrupt_enable, 1'h0);
    // preset flag hides the next write-end event
    flag_wr_en = 10'h004; flag_wr_data = 10'h004; tick; flag_wr_en = '0;
    tick; nv_write_done = 1; tick; nv_write_done = 0;
    cmp(wake_up, 1'h0);
  endtask
  initial begin
    tick(2); reset_n = 1; tick;
    t_serial;
    t_service;
    t_race;
    t_timers;
    t_pin_lv;
    conclude;
  end
endmodule
`default_nettype wire
